// file: logic/pbsp_pkg.sv
/*
 Package for the pipelined burst SRAM port: widths, field layouts, states.
 Assumes one rising-edge clock and a synchronous active-high reset.
*/
package pbsp_pkg;
   localparam int ADDR_W     = 19;
   localparam int LANES      = 4;
   localparam int DATA_W     = 64;
   localparam int PAR_W      = 8;
   localparam int LANE_DW    = 16;
   localparam int LANE_PW    = 2;
   localparam int WORD_W     = 18;
   localparam int DEPTH      = 1024;
   localparam int IDX_W      = 10;
   localparam int SLEEP_CYC  = 2;
   localparam logic [1:0] SLEEP_CNT_MAX = 2'h1;
   localparam logic [1:0] BURST_ZERO    = 2'h0;
   localparam logic [1:0] BURST_ONE     = 2'h1;

   typedef enum logic [1:0] {
      PBSP_IDLE  = 2'b00,
      PBSP_READ  = 2'b01,
      PBSP_WRITE = 2'b10
   } pbsp_op_t;

   typedef enum logic [1:0] {
      PBSP_AWAKE    = 2'b00,
      PBSP_ENTERING = 2'b01,
      PBSP_ASLEEP   = 2'b10,
      PBSP_EXITING  = 2'b11
   } pbsp_pwr_t;

   typedef struct packed {
      logic              chip_select_1_n;
      logic              chip_select_2;
      logic              chip_select_3_n;
      logic              write_n;
      logic              advance_or_load;
      logic [LANES-1:0]  byte_lane_write_n;
      logic [ADDR_W-1:0] addr;
   } pbsp_cmd_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [PAR_W-1:0]  parity_lane;
   } pbsp_bus_t;
endpackage

// file: logic/pbsp_port.sv
/*
 Device side of a pipelined burst SRAM host port with a small internal array.
 Assumes the controller keeps selects, write strobe and strap rules; pins arrive
 asynchronously and are synchronised here, so pin timing is two cycles later.
*/
`timescale 1ns/100ps
`default_nettype none
module pbsp_port
   import pbsp_pkg::*;
(
   input  wire logic       i_mclk,            // System clock
   input  wire logic       i_reset,           // Synchronous reset
   input  wire logic       i_clock_qualify_n, // Clock qualifier, low acts
   input  wire pbsp_cmd_t  i_cmd,             // Command pins
   input  wire logic       i_output_en_n,     // Output drive enable, low drives
   input  wire logic       i_burst_mode,      // Burst-order strap, high interleaved
   input  wire logic       i_burst_mode_oe,   // Strap driven; low means floating
   input  wire logic       i_sleep_request,   // Sleep request level
   input  wire logic       i_sleep_request_oe,// Sleep pin driven; low means floating
   input  wire pbsp_bus_t  i_bus,             // Data and parity pin levels
   output logic            o_sleeping,        // Sleep state reached
   output pbsp_bus_t       o_bus,             // Data and parity drive values
   output logic [LANES-1:0] o_bus_oe_n        // Per-lane drive enable, low drives
);
   typedef struct packed {
      logic       qn;
      pbsp_cmd_t  cmd;
      logic       oe_n;
      logic       mode;
      logic       sleep;
      pbsp_bus_t  bus;
   } pbsp_pins_t;

   pbsp_pins_t pin_a_q, pin_b_q;
   pbsp_pins_t pin_d;

   logic [WORD_W*LANES-1:0] mem_q [DEPTH];

   pbsp_op_t          op_q, op_d, wop_q, wop_d;
   logic [ADDR_W-1:0] base_q, base_d, waddr_q, waddr_d;
   logic [1:0]        cnt_q, cnt_d;
   logic              mode_q, mode_d, desel_q, desel_d, fresh_q, fresh_d;
   logic [LANES-1:0]  wbe_q, wbe_d, oe_n_q, oe_n_d;
   pbsp_bus_t         din_q, din_d, dout_q, dout_d;
   pbsp_pwr_t         pwr_q, pwr_d;
   logic [1:0]        slp_q, slp_d;
   logic              sleeping_q, sleeping_d;
   logic              pw_q, pw_d;
   logic [ADDR_W-1:0] paddr_q, paddr_d;
   logic [LANES-1:0]  pbe_q, pbe_d;

   function automatic logic [1:0] pbsp_burst(input logic [1:0] a0, input logic [1:0] n,
                                             input logic il);
      return il ? (a0 ^ n) : 2'(a0 + n);
   endfunction

   function automatic logic [IDX_W-1:0] pbsp_idx(input logic [ADDR_W-1:0] a);
      return a[IDX_W-1:0];
   endfunction

   // Pin synchroniser; pull-down and pull-up resolve floating pins
   always_comb begin
      pin_d.qn    = i_clock_qualify_n;
      pin_d.cmd   = i_cmd;
      pin_d.oe_n  = i_output_en_n;
      pin_d.mode  = i_burst_mode_oe ? i_burst_mode : 1'b1;
      pin_d.sleep = i_sleep_request_oe & i_sleep_request;
      pin_d.bus   = i_bus;
   end

   always_ff @(posedge i_mclk) begin
      pin_a_q <= pin_d;
      pin_b_q <= pin_a_q;
   end

   logic              act;
   logic              sel;
   logic [ADDR_W-1:0] cur_addr;
   pbsp_bus_t         rd_word;
   logic [WORD_W*LANES-1:0] rd_raw;

   always_comb begin
      act = ~pin_b_q.qn && (pwr_q == PBSP_AWAKE);
      sel = ~pin_b_q.cmd.chip_select_1_n && pin_b_q.cmd.chip_select_2
            && ~pin_b_q.cmd.chip_select_3_n;
      // Address of the beat taken at this edge; a load starts at count zero
      cur_addr = pin_b_q.cmd.advance_or_load ?
                 {base_q[ADDR_W-1:2], pbsp_burst(base_q[1:0], 2'(cnt_q + BURST_ONE), mode_q)} :
                 pin_b_q.cmd.addr;
      rd_raw = mem_q[pbsp_idx(cur_addr)];
      for (int l = 0; l < LANES; l++) begin
         rd_word.data[l*LANE_DW +: LANE_DW]        = rd_raw[l*WORD_W +: LANE_DW];
         rd_word.parity_lane[l*LANE_PW +: LANE_PW] = rd_raw[l*WORD_W+LANE_DW +: LANE_PW];
      end
   end

   // Control pipeline
   always_comb begin
      op_d    = op_q;
      wop_d   = wop_q;
      base_d  = base_q;
      waddr_d = waddr_q;
      cnt_d   = cnt_q;
      mode_d  = mode_q;
      desel_d = desel_q;
      fresh_d = fresh_q;
      wbe_d   = wbe_q;
      din_d   = din_q;
      dout_d  = dout_q;
      oe_n_d  = oe_n_q;
      pw_d    = pw_q;
      paddr_d = paddr_q;
      pbe_d   = pbe_q;
      if (act) begin
         din_d   = pin_b_q.bus;
         wop_d   = pw_q ? PBSP_WRITE : PBSP_IDLE;
         waddr_d = paddr_q;
         wbe_d   = pbe_q;
         pw_d    = 1'b0;
         fresh_d = 1'b0;
         if (!pin_b_q.cmd.advance_or_load) begin
            mode_d = pin_b_q.mode;
            if (sel) begin
               base_d  = pin_b_q.cmd.addr;
               cnt_d   = BURST_ZERO;
               op_d    = pin_b_q.cmd.write_n ? PBSP_READ : PBSP_WRITE;
               fresh_d = desel_q;
               desel_d = 1'b0;
            end else begin
               op_d    = PBSP_IDLE;
               desel_d = 1'b1;
            end
         end else if (op_q != PBSP_IDLE) begin
            cnt_d = 2'(cnt_q + BURST_ONE);
         end
         // Byte selects travel with the address; data follows one active edge later
         if (op_d == PBSP_WRITE) begin
            pw_d    = 1'b1;
            paddr_d = cur_addr;
            pbe_d   = ~pin_b_q.cmd.byte_lane_write_n;
         end
         if (op_d == PBSP_READ) begin
            dout_d = rd_word;
         end
         for (int l = 0; l < LANES; l++) begin
            oe_n_d[l] = pin_b_q.oe_n || (op_d != PBSP_READ) || fresh_d;
         end
      end
      if (pin_b_q.oe_n) begin
         oe_n_d = {LANES{1'b1}};
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         op_q    <= PBSP_IDLE;
         wop_q   <= PBSP_IDLE;
         base_q  <= '0;
         waddr_q <= '0;
         cnt_q   <= BURST_ZERO;
         mode_q  <= 1'b1;
         desel_q <= 1'b1;
         fresh_q <= 1'b0;
         wbe_q   <= '0;
         din_q   <= '0;
         dout_q  <= '0;
         oe_n_q  <= {LANES{1'b1}};
         pw_q    <= 1'b0;
         paddr_q <= '0;
         pbe_q   <= '0;
      end else begin
         op_q    <= op_d;
         wop_q   <= wop_d;
         base_q  <= base_d;
         waddr_q <= waddr_d;
         cnt_q   <= cnt_d;
         mode_q  <= mode_d;
         desel_q <= desel_d;
         fresh_q <= fresh_d;
         wbe_q   <= wbe_d;
         din_q   <= din_d;
         dout_q  <= dout_d;
         oe_n_q  <= oe_n_d;
         pw_q    <= pw_d;
         paddr_q <= paddr_d;
         pbe_q   <= pbe_d;
      end
   end

   // Late write: data captured one active edge after the address
   always_ff @(posedge i_mclk) begin
      if (act && wop_q == PBSP_WRITE) begin
         for (int l = 0; l < LANES; l++) begin
            if (wbe_q[l]) begin
               mem_q[pbsp_idx(waddr_q)][l*WORD_W +: WORD_W] <=
                  {din_q.parity_lane[l*LANE_PW +: LANE_PW], din_q.data[l*LANE_DW +: LANE_DW]};
            end
         end
      end
   end

   // Sleep entry and exit take two cycles; array is never cleared
   always_comb begin
      pwr_d      = pwr_q;
      slp_d      = slp_q;
      sleeping_d = sleeping_q;
      case (pwr_q)
         PBSP_AWAKE: begin
            if (pin_b_q.sleep) begin
               pwr_d = PBSP_ENTERING;
               slp_d = 2'h0;
            end
         end
         PBSP_ENTERING: begin
            if (slp_q == SLEEP_CNT_MAX) begin
               pwr_d      = PBSP_ASLEEP;
               sleeping_d = 1'b1;
            end else begin
               slp_d = 2'(slp_q + 2'h1);
            end
         end
         PBSP_ASLEEP: begin
            if (!pin_b_q.sleep) begin
               pwr_d = PBSP_EXITING;
               slp_d = 2'h0;
            end
         end
         PBSP_EXITING: begin
            if (slp_q == SLEEP_CNT_MAX) begin
               pwr_d      = PBSP_AWAKE;
               sleeping_d = 1'b0;
            end else begin
               slp_d = 2'(slp_q + 2'h1);
            end
         end
         default: pwr_d = PBSP_AWAKE;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         pwr_q      <= PBSP_AWAKE;
         slp_q      <= 2'h0;
         sleeping_q <= 1'b0;
      end else begin
         pwr_q      <= pwr_d;
         slp_q      <= slp_d;
         sleeping_q <= sleeping_d;
      end
   end

   assign o_sleeping = sleeping_q;
   assign o_bus      = dout_q;
   assign o_bus_oe_n = oe_n_q;
endmodule
`default_nettype wire

// file: verification/pbsp_sva.sv
/* Assertions on the burst SRAM port pins.
 Assumes the port's two-flop input synchronisers; windows allow for them. */
`timescale 1ns/100ps
`default_nettype none
module pbsp_sva
   import pbsp_pkg::*;
(
   input wire logic             i_mclk,             // Clock
   input wire logic             i_reset,            // Reset
   input wire logic             i_clock_qualify_n,  // Qualifier
   input wire pbsp_cmd_t        i_cmd,              // Commands
   input wire logic             i_output_en_n,      // Output enable
   input wire logic             i_sleep_request,    // Sleep level
   input wire logic             i_sleep_request_oe, // Sleep driven
   input wire logic             o_sleeping,         // Asleep
   input wire pbsp_bus_t        o_bus,              // Read data
   input wire logic [LANES-1:0] o_bus_oe_n          // Lane drive
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   qual_hold_a: assert property (i_clock_qualify_n [*5] |-> $stable(o_bus))
      else $error("read data moved while clock masked");
   oe_float_a: assert property (i_output_en_n [*4] |-> o_bus_oe_n == 4'hF)
      else $error("lanes driven with output enable high");
   desel_float_a: assert property ((!i_clock_qualify_n && i_cmd.chip_select_1_n
      && !i_cmd.advance_or_load) [*6] |-> o_bus_oe_n == 4'hF) else $error("driving while deselected");
   wr_float_a: assert property ((!i_clock_qualify_n && !i_cmd.write_n && !i_cmd.advance_or_load
      && !i_cmd.chip_select_1_n && i_cmd.chip_select_2 && !i_cmd.chip_select_3_n)
      |-> ##3 o_bus_oe_n == 4'hF) else $error("driving in write data");
   lane_same_a: assert property (o_bus_oe_n == 4'h0 || o_bus_oe_n == 4'hF)
      else $error("lanes disagree on direction");
   sleep_in_a: assert property ((i_sleep_request && i_sleep_request_oe) [*6] |-> o_sleeping)
      else $error("sleep not entered");
   sleep_low_a: assert property ((i_sleep_request_oe && !i_sleep_request) [*6] |-> !o_sleeping)
      else $error("asleep with request low");
   sleep_pull_a: assert property ((!i_sleep_request_oe) [*6] |-> !o_sleeping)
      else $error("asleep with request floating");
endmodule
bind pbsp_port pbsp_sva i_sva (.i_mclk, .i_reset, .i_clock_qualify_n, .i_cmd, .i_output_en_n,
   .i_sleep_request, .i_sleep_request_oe, .o_sleeping, .o_bus, .o_bus_oe_n);
`default_nettype wire

// file: verification/pbsp_ctl.sv
/* Memory controller model facing the SRAM port.
 Assumes the bench resolves the shared data pins from the port's lane drive enables alone. */
`timescale 1ns/100ps
`default_nettype none
module pbsp_ctl
   import pbsp_pkg::*;
(
   input  wire logic       i_mclk,   // Clock
   output pbsp_cmd_t       o_cmd,    // Command pins
   output logic            o_qual_n, // Clock qualifier
   output logic            o_drive,  // Driving data pins
   output pbsp_bus_t       o_bus     // Data pin values
);
   logic [71:0] pend;
   logic        pend_v;
   initial begin
      o_cmd = {3'b101, 2'b10, 4'hF, 19'h0};
      o_qual_n = 1'b0;
      o_drive = 1'b0;
      o_bus = '0;
      pend_v = 1'b0;
      pend = '0;
   end
   // One cycle: command now, data of the previous write beat alongside
   task automatic op(input logic wr, input logic ld, input logic sel, input logic [18:0] a,
                     input logic [3:0] be, input logic [71:0] wd);
      @(posedge i_mclk);
      #1;
      o_cmd = {~sel, sel, ~sel, ~wr, ~ld, be, a};
      o_drive = pend_v;
      o_bus = pend_v ? pend : ~o_bus; // Released lines never keep a stale value
      pend = wd;
      pend_v = wr;
   endtask
   task automatic stall(input int n);
      o_qual_n = 1'b1;
      repeat (n) @(posedge i_mclk);
      #1;
      o_qual_n = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: verification/pbsp_tb.sv
/* Self-checking bench for the burst SRAM port.
 Assumes the controller model and the checker bound to the port. */
`timescale 1ns/100ps
`default_nettype none
module tb;
   import pbsp_pkg::*;
   logic i_mclk = 0, i_reset = 1, i_output_en_n = 0, fresh = 1, il;
   logic i_burst_mode = 0, i_burst_mode_oe = 0, i_sleep_request = 0, i_sleep_request_oe = 0;
   logic q_n, drv, o_sleeping;
   pbsp_cmd_t cmd;
   pbsp_bus_t c_bus, pin, o_bus, last_bus;
   logic [LANES-1:0] o_bus_oe_n, last_oe;
   logic [71:0] mem [int], exp_q [$], e, d, mk;
   logic [18:0] base;
   logic [3:0] be;
   int seed = 32'h8cf2, err_total = 0, n_checks = 0;
   always #2 i_mclk = ~i_mclk;
   pbsp_ctl i_ctl (.i_mclk(i_mclk), .o_cmd(cmd), .o_qual_n(q_n), .o_drive(drv), .o_bus(c_bus));
   pbsp_port i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_clock_qualify_n(q_n), .i_cmd(cmd),
      .i_output_en_n(i_output_en_n), .i_burst_mode(i_burst_mode),
      .i_burst_mode_oe(i_burst_mode_oe), .i_sleep_request(i_sleep_request),
      .i_sleep_request_oe(i_sleep_request_oe), .i_bus(pin), .o_sleeping(o_sleeping),
      .o_bus(o_bus), .o_bus_oe_n(o_bus_oe_n));
   always_comb begin
      pin = c_bus;
      for (int l = 0; l < LANES; l++) begin
         if (!o_bus_oe_n[l]) begin
            pin.data[LANE_DW*l +: LANE_DW] = o_bus.data[LANE_DW*l +: LANE_DW];
            pin.parity_lane[LANE_PW*l +: LANE_PW] = o_bus.parity_lane[LANE_PW*l +: LANE_PW];
         end
      end
   end
   task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] ex);
      n_checks++;
      if (seen !== ex) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   // A new read result shows as a fresh drive or a changed value
   always @(negedge i_mclk) begin
      if (!i_reset && o_bus_oe_n === 4'h0 && (last_oe !== 4'h0 || o_bus !== last_bus)) begin
         e = exp_q.size() ? exp_q.pop_front() : ~o_bus;
         chk("read data", o_bus, e);
      end
      last_oe = o_bus_oe_n;
      last_bus = o_bus;
   end
   function automatic logic [18:0] ba(input int n);
      ba = {base[18:2], il ? base[1:0] ^ 2'(n) : base[1:0] + 2'(n)};
   endfunction
   function automatic logic [71:0] rnd();
      rnd = 72'({$random(seed), $random(seed), $random(seed)});
   endfunction
   task automatic desel(input int n);
      repeat (n) i_ctl.op(0, 1, 0, 19'h0, 4'hF, '0);
      fresh = 1;
   endtask
   // Reads right after a deselect float, so they leave no note
   task automatic rd(input logic [18:0] a, input logic ld);
      i_ctl.op(0, ld, 1, a, 4'hF, '0);
      if (!fresh && !i_output_en_n) exp_q.push_back(mem[int'(a)]);
      fresh = 0;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge i_mclk);
      #1 i_reset = 0;
      desel(4);
      for (int m = 0; m < 3; m++) begin
         i_burst_mode = (m == 1);
         i_burst_mode_oe = (m != 2);
         il = (m != 0);
         base = 19'($random(seed)) & 19'h0_03FF;
         for (int n = 0; n < 4; n++) begin
            d = rnd();
            mem[int'(ba(n))] = d;
            i_ctl.op(1, n == 0, 1, base, 4'h0, d);
         end
         desel(3);
         for (int n = 0; n < 4; n++) rd(ba(n), 1);
         for (int n = 0; n < 4; n++) begin
            rd(ba(n), n == 0);
            if (n == 1) i_ctl.stall(6);
         end
         desel(3);
      end
      be = 4'($random(seed));
      d = rnd();
      mk = '0;
      for (int l = 0; l < LANES; l++) if (!be[l]) mk[8+16*l +: 16] = 16'hFFFF;
      for (int l = 0; l < LANES; l++) if (!be[l]) mk[2*l +: 2] = 2'h3;
      mem[int'(base)] = (d & mk) | (mem[int'(base)] & ~mk);
      i_ctl.op(1, 1, 1, base, be, d);
      desel(3);
      i_output_en_n = 1;
      rd(base, 1);
      rd(ba(1), 1);
      desel(3);
      i_output_en_n = 0;
      i_sleep_request_oe = 1;
      i_sleep_request = 1;
      desel(8);
      chk("sleeping", 72'(o_sleeping), 72'h1);
      i_sleep_request = 0;
      desel(8);
      chk("awake", 72'(o_sleeping), 72'h0);
      rd(base, 1);
      rd(base, 1);
      desel(3);
      for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge i_mclk);
      if (exp_q.size() != 0) err_total++;
      final_report();
   end
endmodule
`default_nettype wire
